// file: rtl/eeprom_pkg.sv
package eeprom_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 25;
  localparam int PROG_TIME_TYP_US = 4000;
  localparam int PROG_TIME_MAX_US = 8000;
  localparam int PROG_CYCLES      = PROG_TIME_TYP_US * CLK_MHZ;
  localparam int SCK_HALF_CYCLES  = 8;
  localparam int DESEL_CYCLES     = 8;
  localparam int STATUS_WAIT      = 8;

  // ----------------------------------------------------------------
  // array shape and contents
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 16;
  localparam int          ADDR_W_DEF = 6;
  localparam logic [15:0] BLANK_WORD = 16'hffff;

  // ----------------------------------------------------------------
  // command encodings after the start bit
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] OP_EXT     = 2'h0;
  localparam logic [1:0] EXT_FILL   = 2'h1;
  localparam logic [1:0] EXT_CLEAR  = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  localparam logic [1:0] EXT_LOCK   = 2'h0;

  typedef enum logic [2:0] {
    CMD_READ   = 3'b000,
    CMD_WRITE  = 3'b001,
    CMD_ERASE  = 3'b010,
    CMD_FILL   = 3'b011,
    CMD_CLEAR  = 3'b100,
    CMD_UNLOCK = 3'b101,
    CMD_LOCK   = 3'b110
  } cmd_t;

endpackage : eeprom_pkg

// file: rtl/eeprom_link.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// four-wire link; serial output line pulled high when undriven
// ------------------------------------------------------------------
interface eeprom_link;
  logic chipSelect;
  logic serialShiftClock;
  logic serialIn;
  logic serialOutData;
  logic serialOutEn;
  logic serialOut;

  assign serialOut = serialOutEn ? serialOutData : 1'b1;

  modport device (
    input  chipSelect,
    input  serialShiftClock,
    input  serialIn,
    output serialOutData,
    output serialOutEn
  );

  modport host (
    output chipSelect,
    output serialShiftClock,
    output serialIn,
    input  serialOut
  );
endinterface : eeprom_link

`default_nettype wire

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// two-stage synchroniser with edge detect on the settled stage
// ------------------------------------------------------------------
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic settled_q;
  logic prev_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_q    <= 1'b0;
      settled_q <= 1'b0;
      prev_q    <= 1'b0;
    end
    else
    begin
      meta_q    <= pinIn;
      settled_q <= meta_q;
      prev_q    <= settled_q;
    end
  end

  assign level = settled_q;
  assign rise  = settled_q & ~prev_q;
  assign fall  = ~settled_q & prev_q;
endmodule : pin_sync

`default_nettype wire

// file: rtl/eeprom_device.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_device
  import eeprom_pkg::*;
#(
  parameter int ADDR_W      = ADDR_W_DEF,
  parameter int PROG_CYC    = PROG_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  eeprom_link.device link,
  output logic      progEnabled,
  output logic      progBusy
);
  if (ADDR_W < 2 || ADDR_W > 16)
    $error("ADDR_W out of range");
  if (PROG_CYC < 2)
    $error("PROG_CYC too small");

  localparam int CNT_W = $clog2(PROG_CYC + 1);

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CMD  = 3'b011,
    ST_RDO  = 3'b100,
    ST_DATA = 3'b101,
    ST_END  = 3'b110,
    ST_PROG = 3'b111
  } dev_state_t;

  dev_state_t        state_q;
  logic [4:0]        bitCnt_q;
  logic [ADDR_W+1:0] cmdSr_q;
  logic [ADDR_W+1:0] cmdNext;
  logic [15:0]       dataSr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addrNext;
  logic [ADDR_W-1:0] sweep_q;
  logic              sweepAll_q;
  logic              sweepDone_q;
  logic [15:0]       wrData_q;
  logic [CNT_W-1:0]  busyCnt_q;
  logic              over_q;
  logic              progEn_q;
  logic              statusShow_q;
  logic              doData_q;
  logic              doEn_q;
  logic              csLvl;
  logic              sckRise;
  logic              diLvl;
  logic              lastCmdBit;
  logic [1:0]        op;
  logic [1:0]        ext;
  logic [1:0]        newOp;
  logic              memWe;
  logic [15:0]       mem [2**ADDR_W];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync csSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   (link.chipSelect),
    .level   (csLvl),
    .rise    (),
    .fall    ()
  );

  pin_sync sckSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   (link.serialShiftClock),
    .level   (),
    .rise    (sckRise),
    .fall    ()
  );

  pin_sync diSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   (link.serialIn),
    .level   (diLvl),
    .rise    (),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign cmdNext    = {cmdSr_q[ADDR_W:0], diLvl};
  assign lastCmdBit = bitCnt_q == 5'(ADDR_W + 1);
  assign newOp      = cmdNext[ADDR_W+1:ADDR_W];
  assign op         = cmdSr_q[ADDR_W+1:ADDR_W];
  assign ext        = cmdSr_q[ADDR_W-1:ADDR_W-2];
  assign addrNext   = addr_q + 1'b1;

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  assign memWe = (state_q == ST_INIT) ||
                 (state_q == ST_PROG && !sweepDone_q);

  always_ff @(posedge clk_sys)
  begin
    if (memWe)
      mem[sweep_q] <= (state_q == ST_INIT) ? BLANK_WORD : wrData_q;
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q      <= ST_INIT;
      bitCnt_q     <= 5'h00;
      cmdSr_q      <= '0;
      dataSr_q     <= 16'h0000;
      addr_q       <= '0;
      sweep_q      <= '0;
      sweepAll_q   <= 1'b0;
      sweepDone_q  <= 1'b1;
      wrData_q     <= 16'h0000;
      busyCnt_q    <= '0;
      over_q       <= 1'b0;
      progEn_q     <= 1'b0;
      statusShow_q <= 1'b0;
    end
    else if (state_q == ST_INIT)
    begin
      sweep_q <= sweep_q + 1'b1;
      if (&sweep_q)
        state_q <= ST_IDLE;
    end
    else if (state_q == ST_PROG)
    begin
      // pins are not looked at here
      busyCnt_q <= busyCnt_q + 1'b1;
      if (!sweepDone_q)
      begin
        sweep_q <= sweep_q + 1'b1;
        if (!sweepAll_q || &sweep_q)
          sweepDone_q <= 1'b1;
      end
      if (busyCnt_q == CNT_W'(PROG_CYC - 1))
        state_q <= ST_IDLE;
    end
    else if (!csLvl)
    begin
      state_q <= ST_IDLE;
      if (state_q == ST_END && !over_q)
      begin
        if (op == OP_EXT && ext == EXT_UNLOCK)
          progEn_q <= 1'b1;
        else if (op == OP_EXT && ext == EXT_LOCK)
          progEn_q <= 1'b0;
        else if (progEn_q)
        begin
          state_q      <= ST_PROG;
          busyCnt_q    <= '0;
          statusShow_q <= 1'b1;
          sweepDone_q  <= 1'b0;
          sweepAll_q   <= op == OP_EXT;
          sweep_q      <= (op == OP_EXT) ? '0 : cmdSr_q[ADDR_W-1:0];
          wrData_q     <= (op == OP_WRITE ||
                           (op == OP_EXT && ext == EXT_FILL)) ?
                          dataSr_q : BLANK_WORD;
        end
      end
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          state_q <= ST_WAIT;
        ST_WAIT:
          if (sckRise && diLvl)
          begin
            state_q      <= ST_CMD;
            bitCnt_q     <= 5'h00;
            statusShow_q <= 1'b0;
          end
        ST_CMD:
          if (sckRise)
          begin
            cmdSr_q  <= cmdNext;
            bitCnt_q <= bitCnt_q + 5'h01;
            over_q   <= 1'b0;
            if (lastCmdBit)
            begin
              bitCnt_q <= 5'h00;
              if (newOp == OP_READ)
              begin
                state_q  <= ST_RDO;
                addr_q   <= cmdNext[ADDR_W-1:0];
                dataSr_q <= mem[cmdNext[ADDR_W-1:0]];
              end
              else if (newOp == OP_WRITE ||
                       (newOp == OP_EXT &&
                        cmdNext[ADDR_W-1:ADDR_W-2] == EXT_FILL))
                state_q <= ST_DATA;
              else
                state_q <= ST_END;
            end
          end
        ST_DATA:
          if (sckRise)
          begin
            dataSr_q <= {dataSr_q[14:0], diLvl};
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == 5'h0f)
              state_q <= ST_END;
          end
        ST_END:
          if (sckRise)
            over_q <= 1'b1;
        ST_RDO:
          if (sckRise)
          begin
            if (bitCnt_q == 5'h0f)
            begin
              bitCnt_q <= 5'h00;
              addr_q   <= addrNext;
              dataSr_q <= mem[addrNext];
            end
            else
            begin
              bitCnt_q <= bitCnt_q + 5'h01;
              dataSr_q <= {dataSr_q[14:0], 1'b0};
            end
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial output driver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset || !csLvl)
    begin
      doEn_q   <= 1'b0;
      doData_q <= 1'b0;
    end
    else if (state_q == ST_CMD && sckRise && lastCmdBit &&
             newOp == OP_READ)
    begin
      doEn_q   <= 1'b1;
      doData_q <= 1'b0;
    end
    else if (state_q == ST_RDO)
    begin
      doEn_q <= 1'b1;
      if (sckRise)
        doData_q <= dataSr_q[15];
    end
    else if (statusShow_q && (state_q == ST_PROG ||
             state_q == ST_IDLE || state_q == ST_WAIT) &&
             !(state_q == ST_WAIT && sckRise && diLvl))
    begin
      doEn_q   <= 1'b1;
      doData_q <= state_q != ST_PROG;
    end
    else
    begin
      doEn_q   <= 1'b0;
      doData_q <= 1'b0;
    end
  end

  assign link.serialOutData = doData_q;
  assign link.serialOutEn   = doEn_q;
  assign progEnabled        = progEn_q;
  assign progBusy           = state_q == ST_PROG;
endmodule : eeprom_device

`default_nettype wire

// file: rtl/eeprom_host.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_host
  import eeprom_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int HALF   = SCK_HALF_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire cmd_t              cmdOp,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [15:0]       cmdData,
  input  wire logic [7:0]        readWords,
  output logic [15:0]            rdData,
  output logic                   rdValid,
  output logic                   opDone,
  eeprom_link.host               link
);
  if (ADDR_W < 2 || ADDR_W > 16 || HALF < 4)
    $error("bad host parameters");

  localparam int FR_W = 19 + ADDR_W;
  localparam int PH_W = $clog2(2 * HALF);

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_SEL    = 3'b001,
    H_SHIFT  = 3'b010,
    H_DESEL  = 3'b011,
    H_VERIFY = 3'b100,
    H_DONE   = 3'b101
  } host_state_t;

  host_state_t     state_q;
  logic [FR_W-1:0] frame_q;
  logic [15:0]     total_q;
  logic [15:0]     rises_q;
  logic [PH_W-1:0] ph_q;
  logic [3:0]      rdBit_q;
  logic [15:0]     rdSr_q;
  logic [7:0]      wait_q;
  logic            isRead_q;
  logic            isProg_q;
  logic            cs_q;
  logic            sck_q;
  logic            doLvl;
  logic [1:0]      opBits;
  logic [ADDR_W-1:0] field;
  logic            hasData;

  pin_sync doSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   (link.serialOut),
    .level   (doLvl),
    .rise    (),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // frame build
  // ----------------------------------------------------------------
  always_comb
  begin
    opBits  = OP_EXT;
    field   = '0;
    hasData = 1'b0;
    case (cmdOp)
      CMD_READ:   begin opBits = OP_READ;  field = cmdAddr; end
      CMD_WRITE:  begin opBits = OP_WRITE; field = cmdAddr; hasData = 1'b1; end
      CMD_ERASE:  begin opBits = OP_ERASE; field = cmdAddr; end
      CMD_FILL:   begin field[ADDR_W-1 -: 2] = EXT_FILL; hasData = 1'b1; end
      CMD_CLEAR:  field[ADDR_W-1 -: 2] = EXT_CLEAR;
      CMD_UNLOCK: field[ADDR_W-1 -: 2] = EXT_UNLOCK;
      CMD_LOCK:   field[ADDR_W-1 -: 2] = EXT_LOCK;
      default:    field = '0;
    endcase
  end

  assign cmdReady = state_q == H_IDLE;

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q  <= H_IDLE;
      frame_q  <= '0;
      total_q  <= 16'h0000;
      rises_q  <= 16'h0000;
      ph_q     <= '0;
      rdBit_q  <= 4'h0;
      rdSr_q   <= 16'h0000;
      rdData   <= 16'h0000;
      rdValid  <= 1'b0;
      opDone   <= 1'b0;
      wait_q   <= 8'h00;
      isRead_q <= 1'b0;
      isProg_q <= 1'b0;
      cs_q     <= 1'b0;
      sck_q    <= 1'b0;
    end
    else
    begin
      rdValid <= 1'b0;
      opDone  <= 1'b0;
      case (state_q)
        H_IDLE:
          if (cmdValid)
          begin
            frame_q  <= {1'b1, opBits, field, cmdData};
            total_q  <= 16'(3 + ADDR_W) + (hasData ? 16'h0010 : 16'h0000) +
                        ((cmdOp == CMD_READ) ? {4'h0, readWords, 4'h0}
                                             : 16'h0000);
            isRead_q <= cmdOp == CMD_READ;
            isProg_q <= !(cmdOp == CMD_READ || cmdOp == CMD_UNLOCK ||
                          cmdOp == CMD_LOCK);
            rises_q  <= 16'h0000;
            rdBit_q  <= 4'h0;
            wait_q   <= 8'h00;
            cs_q     <= 1'b1;
            state_q  <= H_SEL;
          end
        H_SEL:
        begin
          wait_q <= wait_q + 8'h01;
          if (wait_q == 8'(HALF - 1))
          begin
            ph_q    <= '0;
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          ph_q <= ph_q + 1'b1;
          if (ph_q == PH_W'(HALF - 1))
          begin
            if (isRead_q && rises_q > 16'(3 + ADDR_W))
            begin
              rdSr_q  <= {rdSr_q[14:0], doLvl};
              rdBit_q <= rdBit_q + 4'h1;
              if (rdBit_q == 4'hf)
              begin
                rdData  <= {rdSr_q[14:0], doLvl};
                rdValid <= 1'b1;
              end
            end
            if (rises_q == total_q)
            begin
              cs_q    <= 1'b0;
              wait_q  <= 8'h00;
              state_q <= H_DESEL;
            end
            else
            begin
              sck_q   <= 1'b1;
              rises_q <= rises_q + 16'h0001;
            end
          end
          else if (ph_q == PH_W'(2 * HALF - 1))
          begin
            sck_q   <= 1'b0;
            ph_q    <= '0;
            frame_q <= {frame_q[FR_W-2:0], 1'b0};
          end
        end
        H_DESEL:
        begin
          wait_q <= wait_q + 8'h01;
          if (wait_q == 8'(DESEL_CYCLES - 1))
          begin
            wait_q <= 8'h00;
            if (isProg_q)
            begin
              cs_q    <= 1'b1;
              state_q <= H_VERIFY;
            end
            else
              state_q <= H_DONE;
          end
        end
        H_VERIFY:
        begin
          if (wait_q != 8'(STATUS_WAIT))
            wait_q <= wait_q + 8'h01;
          else if (doLvl)
          begin
            cs_q     <= 1'b0;
            isProg_q <= 1'b0;
            wait_q   <= 8'h00;
            state_q  <= H_DESEL;
          end
        end
        H_DONE:
        begin
          opDone  <= 1'b1;
          state_q <= H_IDLE;
        end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  assign link.chipSelect       = cs_q;
  assign link.serialShiftClock = sck_q;
  assign link.serialIn         = frame_q[FR_W-1] & (state_q == H_SHIFT);
endmodule : eeprom_host

`default_nettype wire

// file: bench/serial_eeprom_command_port_checker.sv
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_command_port_checker #(
  parameter int PROG_CYC = 200
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chipSelect,
  input wire logic serialShiftClock,
  input wire logic serialIn,
  input wire logic serialOutData,
  input wire logic serialOutEn,
  input wire logic serialOut
);
  // ----------------
  // helper counters
  // ----------------
  logic sck_q;
  logic sckRise;
  int   csCnt_q;
  int   riseCnt_q;
  int   lowCnt_q;
  assign sckRise = serialShiftClock && !sck_q;
  always_ff @(posedge clk_sys) sck_q <= reset ? 1'b0 : serialShiftClock;
  always_ff @(posedge clk_sys)
  begin
    if (reset || !chipSelect) csCnt_q <= 0;
    else if (csCnt_q < 99) csCnt_q <= csCnt_q + 1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset || sckRise) riseCnt_q <= 0;
    else if (riseCnt_q < 99) riseCnt_q <= riseCnt_q + 1;
  end
  // busy shows as a low output with the link clock stopped
  always_ff @(posedge clk_sys)
  begin
    if (reset || sckRise || serialOut) lowCnt_q <= 0;
    else lowCnt_q <= lowCnt_q + 1;
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_released;
    !chipSelect [*6] |-> !serialOutEn;
  endproperty
  a_released: assert property (p_released)
    else $error("output driven while deselected");
  property p_enSelect;
    $rose(serialOutEn) |-> chipSelect && $past(chipSelect, 2);
  endproperty
  a_enSelect: assert property (p_enSelect)
    else $error("output enabled without select");
  property p_readLow;
    $rose(serialOutEn) && csCnt_q > 24 |-> !serialOutData;
  endproperty
  a_readLow: assert property (p_readLow)
    else $error("read output not led by low bit");
  property p_bitOnRise;
    serialOutEn && $past(serialOutEn) && $fell(serialOutData)
      |-> riseCnt_q < 8;
  endproperty
  a_bitOnRise: assert property (p_bitOnRise)
    else $error("output bit changed away from a clock rise");
  property p_sckSel;
    $rose(serialShiftClock) |-> chipSelect;
  endproperty
  a_sckSel: assert property (p_sckSel)
    else $error("link clock rose while deselected");
  property p_sckHigh;
    $rose(serialShiftClock) |=> serialShiftClock [*3];
  endproperty
  a_sckHigh: assert property (p_sckHigh)
    else $error("link clock high phase too short");
  property p_gap;
    $fell(chipSelect) |=> !chipSelect [*7];
  endproperty
  a_gap: assert property (p_gap)
    else $error("select low gap too short");
  property p_idle;
    !chipSelect |-> !serialShiftClock && !serialIn;
  endproperty
  a_idle: assert property (p_idle)
    else $error("link active while deselected");
  // busy status only: read data may be low while the address bit stands
  property p_quietBusy;
    serialOutEn && !serialOutData && riseCnt_q > 24 |-> !serialIn;
  endproperty
  a_quietBusy: assert property (p_quietBusy)
    else $error("input high while output low");
  property p_progTime;
    lowCnt_q <= PROG_CYC + 40;
  endproperty
  a_progTime: assert property (p_progTime)
    else $error("busy status held too long");
  c_read: cover property ($rose(serialOutEn) && csCnt_q > 24);
  c_busy: cover property (serialOutEn && !serialOutData && chipSelect);
  c_ready: cover property (serialOutEn && $rose(serialOutData));
endmodule : serial_eeprom_command_port_checker

`default_nettype wire

// file: bench/test_serial_eeprom_command_port.sv
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_command_port;
  import eeprom_pkg::*;
  // ----------------
  // design and link
  // ----------------
  localparam int AW = ADDR_W_DEF;
  localparam int PC = 200;
  logic          clk_sys   = 1'b0;
  logic          reset     = 1'b1;
  logic          cmdValid  = 1'b0;
  cmd_t          cmdOp     = CMD_READ;
  logic [AW-1:0] cmdAddr   = '0;
  logic [15:0]   cmdData   = 16'h0000;
  logic [7:0]    readWords = 8'h00;
  logic          cmdReady;
  logic          rdValid;
  logic          opDone;
  logic          progEnabled;
  logic          progBusy;
  logic          enB;
  logic          busyB;
  logic [15:0]   rdData;
  logic [15:0]   mem [2**AW];
  logic [15:0]   got [$];
  logic [31:0]   shB;
  logic          unlocked  = 1'b0;
  int            busyCnt   = 0;
  int            errors    = 0;
  int            checked   = 0;
  eeprom_link link ();
  eeprom_link linkB ();
  eeprom_device #(.ADDR_W(AW), .PROG_CYC(PC)) u_eeprom_device (
    .clk_sys(clk_sys), .reset(reset), .link(link),
    .progEnabled(progEnabled), .progBusy(progBusy));
  eeprom_device #(.ADDR_W(AW), .PROG_CYC(PC)) u_eeprom_device_b (
    .clk_sys(clk_sys), .reset(reset), .link(linkB),
    .progEnabled(enB), .progBusy(busyB));
  eeprom_host #(.ADDR_W(AW)) u_eeprom_host (
    .clk_sys(clk_sys), .reset(reset), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .readWords(readWords), .rdData(rdData),
    .rdValid(rdValid), .opDone(opDone), .link(link));
  serial_eeprom_command_port_checker #(.PROG_CYC(PC)) u_checker (
    .clk_sys(clk_sys), .reset(reset), .chipSelect(link.chipSelect),
    .serialShiftClock(link.serialShiftClock), .serialIn(link.serialIn),
    .serialOutData(link.serialOutData), .serialOutEn(link.serialOutEn),
    .serialOut(link.serialOut));
  always #(20) clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (progBusy === 1'b1) busyCnt++;
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("Error %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic void model(input cmd_t op, input logic [AW-1:0] a,
                                input logic [15:0] d);
    if (op == CMD_UNLOCK) unlocked = 1'b1;
    if (op == CMD_LOCK) unlocked = 1'b0;
    if (unlocked && op == CMD_WRITE) mem[a] = d;
    if (unlocked && op == CMD_ERASE) mem[a] = BLANK_WORD;
    if (unlocked && op == CMD_FILL) foreach (mem[i]) mem[i] = d;
    if (unlocked && op == CMD_CLEAR) foreach (mem[i]) mem[i] = BLANK_WORD;
  endfunction : model
  task automatic run(input cmd_t op, input logic [AW-1:0] a,
                     input logic [15:0] d, input logic [7:0] n);
    int   t;
    logic prog;
    prog = unlocked && op inside {CMD_WRITE, CMD_ERASE, CMD_FILL, CMD_CLEAR};
    got.delete();
    busyCnt = 0;
    @(posedge clk_sys);
    cmdOp <= op;
    cmdAddr <= a;
    cmdData <= d;
    readWords <= n;
    cmdValid <= 1'b1;
    @(negedge clk_sys);
    while (cmdReady !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys) cmdValid <= 1'b0;
    t = 0;
    while (opDone !== 1'b1 && t < 20000)
    begin
      @(negedge clk_sys);
      t++;
      if (rdValid === 1'b1) got.push_back(rdData);
    end
    chk(16'(opDone === 1'b1), 16'h0001);
    model(op, a, d);
    chk(16'(busyCnt != 0), 16'(prog));
    chk(16'(busyCnt <= PC + 8), 16'h0001);
    chk(16'(progEnabled), 16'(unlocked));
    chk(16'(got.size()), 16'(n));
    for (int i = 0; i < n; i++) chk(got[i], mem[a + AW'(i)]);
    $display("test op %0d at %0d done", op, a);
  endtask : run
  // bench drives the second link, link clock 320 ns
  task automatic bang(input int n, input logic [31:0] bits);
    @(posedge clk_sys) linkB.chipSelect <= 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk_sys) linkB.serialIn <= bits[i];
      repeat (3) @(negedge clk_sys);
      shB = {shB[30:0], linkB.serialOut};
      @(posedge clk_sys) linkB.serialShiftClock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      linkB.serialShiftClock <= 1'b0;
    end
  endtask : bang
  task automatic deselB;
    @(posedge clk_sys) linkB.chipSelect <= 1'b0;
    linkB.serialIn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : deselB
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ----------------
  // sequence
  // ----------------
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    $display("Error %0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    logic [AW-1:0] a;
    logic [15:0]   d;
    logic [24:0]   wfr;
    linkB.chipSelect = 1'b0;
    linkB.serialShiftClock = 1'b0;
    linkB.serialIn = 1'b0;
    shB = 32'h0;
    foreach (mem[i]) mem[i] = BLANK_WORD;
    void'($urandom(32'h82b2e2be));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (100) @(posedge clk_sys);
    run(CMD_READ, AW'(62), 16'h0000, 8'h04);
    run(CMD_WRITE, AW'(5), 16'($urandom), 8'h00);
    run(CMD_READ, AW'(5), 16'h0000, 8'h01);
    run(CMD_UNLOCK, '0, 16'h0000, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      a = (k == 0) ? '0 : (k == 1) ? '1 : AW'($urandom);
      d = (k == 2) ? 16'h0000 : 16'($urandom);
      run(CMD_WRITE, a, d, 8'h00);
      run(CMD_READ, a - 1'b1, 16'h0000, 8'h03);
    end
    run(CMD_ERASE, '1, 16'h0000, 8'h00);
    run(CMD_FILL, '0, 16'($urandom), 8'h00);
    run(CMD_READ, '1, 16'h0000, 8'h03);
    run(CMD_CLEAR, '0, 16'h0000, 8'h00);
    run(CMD_WRITE, AW'(9), 16'($urandom), 8'h00);
    run(CMD_LOCK, '0, 16'h0000, 8'h00);
    run(CMD_ERASE, AW'(9), 16'h0000, 8'h00);
    run(CMD_READ, AW'(8), 16'h0000, 8'h02);
    wfr = {1'b1, OP_WRITE, 6'h2a, 16'h5a3c};
    bang(14, 32'({1'b1, OP_EXT, EXT_UNLOCK, 4'h0}));
    deselB;
    chk(16'(enB), 16'h0001);
    bang(26, 32'({wfr, 1'b0}));
    deselB;
    chk(16'(busyB), 16'h0000);
    bang(24, 32'(wfr[24:1]));
    deselB;
    chk(16'(busyB), 16'h0000);
    bang(25, 32'(wfr));
    deselB;
    chk(16'(busyB), 16'h0001);
    @(posedge clk_sys) linkB.chipSelect <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(16'(linkB.serialOut), 16'h0000);
    repeat (PC) @(negedge clk_sys);
    chk(16'(linkB.serialOut), 16'h0001);
    bang(26, 32'({1'b1, OP_READ, 6'h2a, 17'h0}));
    deselB;
    chk(shB[15:0], 16'h5a3c);
    chk(16'(shB[16]), 16'h0000);
    $display("test second link done");
    finish_test();
  end
endmodule : test_serial_eeprom_command_port

`default_nettype wire
